// >>> pwmcd_map.svh
// Register indices, field positions, reset values and counts of the modulator block.
`ifndef PWMCD_MAP_SVH
`define PWMCD_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define PWMCD_IDX_LOCK      8'hC0
`define PWMCD_IDX_OUT_EN    8'hC1
`define PWMCD_IDX_FAULT     8'hC2
`define PWMCD_IDX_CH0_DT    8'hD1
`define PWMCD_IDX_CH1_DT    8'hD7
`define PWMCD_IDX_CH1_CTL   8'hD9
`define PWMCD_IDX_CH1_PER   8'hDA
`define PWMCD_IDX_CH1_DUTY  8'hDB
`define PWMCD_IDX_CH2_DT    8'hDC
`define PWMCD_IDX_CH2_CTL   8'hDD
`define PWMCD_IDX_CH2_PER   8'hDE
`define PWMCD_IDX_CH2_DUTY  8'hDF

// Channel control register fields.
`define PWMCD_CTL_IE        7
`define PWMCD_CTL_IF        6
`define PWMCD_CTL_POL       2
`define PWMCD_CTL_SEL_HI    1
`define PWMCD_CTL_SEL_LO    0

// Output enable register fields: primary enables low, complement enables high.
`define PWMCD_EN_PRIM_LO    0
`define PWMCD_EN_COMP_LO    4

// Fault register fields.
`define PWMCD_FLT_EN        0
`define PWMCD_FLT_LATCH     1

// Values and counts.
`define PWMCD_UNLOCK        8'h55
`define PWMCD_RST8          8'h00
`define PWMCD_RST4          4'h0
`define PWMCD_DT_MIN        8'h02
`define PWMCD_RD_PAD        24'h00_0000
`define PWMCD_PRE_RST       4'h0

`endif

// >>> pwmcd_pkg.sv
// Types shared by the modulator top level and its channel engine.
package pwmcd_pkg;

    // Settings a channel copies in at each period start.
    typedef struct packed {
        logic       pol;     // Output polarity bit.
        logic [1:0] sel;     // Clock divider select.
        logic [7:0] period;  // Period value.
        logic [7:0] duty;    // Duty value.
    } pwmcd_cfg_t;

    // Per-channel enables.
    typedef struct packed {
        logic prim_en;  // Channel output enable.
        logic comp_en;  // Complement output enable.
    } pwmcd_en_t;

    // Per-channel output pins.
    typedef struct packed {
        logic prim;  // Primary output.
        logic comp;  // Complementary output.
    } pwmcd_pins_t;

endpackage

// >>> pwmcd_chan.sv
// One 8-bit modulator channel with complementary output and dead time.
`timescale 1ns/10ps
`include "pwmcd_map.svh"
module pwmcd_chan (
    input  wire logic                 mclk_i,
    input  wire logic                 resetn_i,
    input  wire logic [3:0]           tick_i,
    input  wire pwmcd_pkg::pwmcd_cfg_t cfg_i,
    input  wire pwmcd_pkg::pwmcd_en_t  en_i,
    input  wire logic [7:0]           dead_i,
    input  wire logic                 fault_i,
    output pwmcd_pkg::pwmcd_pins_t    pins_o,
    output logic                      ovf_o
);
    import pwmcd_pkg::*;

    pwmcd_cfg_t cfg_act;   // Settings in force for the current period.
    logic [7:0] cnt;       // Period counter.
    logic       act_q;     // Active phase seen one cycle ago.
    logic [7:0] run_cnt;   // Oscillator clocks since the active phase last changed.
    logic       running;   // Either output wants the counter.
    logic       tick;      // Modulator clock enable picked by the divider select in force for the current period.
    logic       last;      // Counter is at the final step of the period.
    logic       act;       // Raw active phase before dead time.
    logic [7:0] dt_eff;    // Dead time in force, floored at its minimum.
    logic       gate;      // Dead time after the last phase change has elapsed.
    logic       narrow;    // Off time too short for two dead times.

    assign running = en_i.prim_en | en_i.comp_en;
    assign tick    = tick_i[cfg_act.sel];
    assign last    = (cfg_act.period == `PWMCD_RST8) ||
                     (({1'b0, cnt} + 9'h001) >= {1'b0, cfg_act.period});
    // Active while inside the duty count; never with a zero period, always when the
    // period does not exceed the duty.
    assign act     = (cfg_act.period != `PWMCD_RST8) &&
                     ((cfg_act.period <= cfg_act.duty) || (cnt < cfg_act.duty));
    // Dead time applies only with the complement running; short settings are stretched.
    assign dt_eff  = (!en_i.comp_en || dead_i == `PWMCD_RST8) ? `PWMCD_RST8 :
                     ((dead_i < `PWMCD_DT_MIN) ? `PWMCD_DT_MIN : dead_i);
    assign gate    = (dt_eff == `PWMCD_RST8) ||
                     ((act == act_q) && ({1'b0, run_cnt} + 9'h001 >= {1'b0, dt_eff}));
    assign narrow  = (cfg_act.period == `PWMCD_RST8) ||
                     ((cfg_act.period > cfg_act.duty) &&
                      (({1'b0, cfg_act.period} - {1'b0, cfg_act.duty}) <=
                       {dt_eff, 1'b0}));

    // Period counter; new settings are copied only when a period ends, so a write
    // never cuts a period short. While idle it tracks the registers for a clean start.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_act <= '0;
            cnt     <= `PWMCD_RST8;
            ovf_o   <= 1'b0;
        end else if (!running) begin
            cfg_act <= cfg_i;
            cnt     <= `PWMCD_RST8;
            ovf_o   <= 1'b0;
        end else if (tick && last) begin
            cfg_act <= cfg_i;
            cnt     <= `PWMCD_RST8;
            ovf_o   <= (cfg_act.period != `PWMCD_RST8);
        end else begin
            cnt     <= tick ? cnt + 8'h01 : cnt;
            ovf_o   <= 1'b0;
        end
    end

    // Dead time counter runs on the raw oscillator clock, not the modulator clock.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            act_q   <= 1'b0;
            run_cnt <= `PWMCD_RST8;
        end else begin
            act_q   <= act;
            if (act != act_q) begin
                run_cnt <= `PWMCD_RST8;
            end else if (run_cnt != 8'hFF) begin
                run_cnt <= run_cnt + 8'h01;
            end
        end
    end

    // Output stage; a fault or a disabled output rests at the inactive level.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pins_o <= '0;
        end else if (fault_i) begin
            pins_o.prim <= cfg_act.pol;
            pins_o.comp <= cfg_act.pol;
        end else begin
            pins_o.prim <= en_i.prim_en ? ((act & gate) ^ cfg_act.pol) : cfg_act.pol;
            pins_o.comp <= en_i.comp_en ?
                           ((~act & gate & ~narrow) ^ cfg_act.pol) : cfg_act.pol;
        end
    end

endmodule

// >>> pwmcd_top.sv
// Top level: Avalon-MM register file, prescaler, fault input and two modulator channels.
//
// Overview of operation
// - Period equals period value times modulator clock.
// - Zero period, polarity 0: output held low.
// - Zero period, polarity 1: output held high.
// - Active time equals duty value times modulator clock.
// - Period not above duty, polarity 0: constant high.
// - Period not above duty, polarity 1: constant low.
// - Modulator settings change only while unlock held; flag clears need no unlock.
// - Waveform appears only after enable bit set.
// - New period or duty apply next period.
// - Polarity and divider changes apply next period.
// - No dead time, nonzero period: complement is inverted primary.
// - Complement runs even with primary disabled.
// - Fault forces both outputs to inactive level.
// - Dead time between edges, same period kept.
// - Dead time writes ignored while outputs enabled.
// - Short off time: complement held at inactive.
// - Dead time counts oscillator clocks, minimum two.
// - Dead time equals value times oscillator clock.
// - Polarity selects active level during duty time.
// - Divider select gives oscillator over 2,4,8,16.
// - Overflow sets flag; software clears; request gated.
`timescale 1ns/10ps
`include "pwmcd_map.svh"
module pwmcd_top #(
    parameter int NCH = 2  // Number of 8-bit channels.
) (
    input  wire logic                        mclk_i,
    input  wire logic                        resetn_i,
    input  wire logic [9:0]                  avs_address_i,
    input  wire logic                        avs_read_i,
    input  wire logic                        avs_write_i,
    input  wire logic [31:0]                 avs_writedata_i,
    input  wire logic [3:0]                  avs_byteenable_i,
    output logic      [31:0]                 avs_readdata_o,
    output logic                             avs_waitrequest_o,
    input  wire logic                        fault_n_i,
    output pwmcd_pkg::pwmcd_pins_t [NCH-1:0] chan_pins_o,
    output logic      [NCH-1:0]              irq_req_o
);
    import pwmcd_pkg::*;

    // Register indices of each channel, channel 0 of the array being channel 1.
    localparam logic [1:0][7:0] CTL_IDX  = {`PWMCD_IDX_CH2_CTL,  `PWMCD_IDX_CH1_CTL};
    localparam logic [1:0][7:0] PER_IDX  = {`PWMCD_IDX_CH2_PER,  `PWMCD_IDX_CH1_PER};
    localparam logic [1:0][7:0] DUTY_IDX = {`PWMCD_IDX_CH2_DUTY, `PWMCD_IDX_CH1_DUTY};
    localparam logic [1:0][7:0] DT_IDX   = {`PWMCD_IDX_CH2_DT,   `PWMCD_IDX_CH1_DT};

    // Bus decode.
    logic [7:0]  idx;        // Register index from the byte address.
    logic [7:0]  wdat;       // Low byte of the write data.
    logic        wr_go;      // Write completes at this edge.
    logic        rd_load;    // Read data is captured at this edge.
    logic        unlocked;   // Lock register holds the unlock value.
    logic        mod_wr;     // Write to a protected modulator register.
    logic [7:0]  rd_mux;     // Read data selected by index.

    // Software-visible state.
    logic [7:0]     lock;       // Write lock register.
    logic [3:0]     out_en;     // Channel and complement output enables.
    logic           flt_en;     // Fault detect enable.
    logic           flt_latch;  // Fault seen, held until software clears it.
    logic [7:0]     ch0_dt;     // Dead time of the 12-bit channel, held for its engine.
    logic [NCH-1:0] ie;         // Overflow interrupt enables.
    logic [NCH-1:0] iflag;      // Overflow flags.
    logic [NCH-1:0] ovf;        // Overflow pulses from the channels.
    pwmcd_cfg_t [NCH-1:0] cfg;  // Programmed channel settings.
    logic [NCH-1:0][7:0]  dt;   // Programmed dead times.

    // Shared timing.
    logic [3:0] pre;    // Free-running oscillator prescaler.
    logic [3:0] tick;   // One-cycle enables at oscillator over 2, 4, 8 and 16.
    logic       flt_meta;  // First synchroniser stage of the fault pin.
    logic       flt_sync;  // Second synchroniser stage of the fault pin.

    assign idx      = avs_address_i[9:2];
    assign wdat     = avs_writedata_i[7:0];
    assign wr_go    = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    assign rd_load  = avs_read_i && avs_waitrequest_o;
    assign unlocked = (lock == `PWMCD_UNLOCK);
    assign mod_wr   = wr_go && unlocked;

    // Wait state generator: every access waits exactly one cycle, so the read data
    // captured on the first edge stands while waitrequest is low.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    // Read data register; unmapped indices and the unused upper bits read as zero.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_readdata_o <= {`PWMCD_RD_PAD, `PWMCD_RST8};
        end else if (rd_load) begin
            avs_readdata_o <= {`PWMCD_RD_PAD, rd_mux};
        end
    end

    // The prescaler runs freely so that all channels share one phase; a channel
    // restarting mid-count may see its first modulator tick early by a few clocks.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pre <= `PWMCD_PRE_RST;
        end else begin
            pre <= pre + 4'h1;
        end
    end

    // Tick for division by 2 to the power s+1 fires when the low s+1 bits are all ones.
    genvar s;
    generate
        for (s = 0; s < 4; s++) begin : g_tick
            assign tick[s] = &pre[s:0];
        end
    endgenerate

    // The fault pin comes from outside and passes two flip-flops first.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flt_meta <= 1'b1;
            flt_sync <= 1'b1;
        end else begin
            flt_meta <= fault_n_i;
            flt_sync <= flt_meta;
        end
    end

    // Lock register is always writable; only its value opens the others.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock <= `PWMCD_RST8;
        end else if (wr_go && idx == `PWMCD_IDX_LOCK) begin
            lock <= wdat;
        end
    end

    // Output enables, guarded by the lock.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_en <= `PWMCD_RST4;
        end else if (mod_wr && idx == `PWMCD_IDX_OUT_EN) begin
            out_en <= {wdat[`PWMCD_EN_COMP_LO+1:`PWMCD_EN_COMP_LO],
                       wdat[`PWMCD_EN_PRIM_LO+1:`PWMCD_EN_PRIM_LO]};
        end
    end

    // Fault control: a low level on the pin while enabled latches the fault. Writing
    // one to the latch bit clears it, but a fault in the same cycle wins.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flt_en    <= 1'b0;
            flt_latch <= 1'b0;
        end else begin
            if (mod_wr && idx == `PWMCD_IDX_FAULT) begin
                flt_en <= wdat[`PWMCD_FLT_EN];
            end
            if (flt_en && !flt_sync) begin
                flt_latch <= 1'b1;
            end else if (wr_go && idx == `PWMCD_IDX_FAULT && wdat[`PWMCD_FLT_LATCH]) begin
                flt_latch <= 1'b0;
            end
        end
    end

    // The 12-bit channel's dead time is only stored here for its own engine.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ch0_dt <= `PWMCD_RST8;
        end else if (mod_wr && idx == `PWMCD_IDX_CH0_DT) begin
            ch0_dt <= wdat;
        end
    end

    // Per-channel registers and engines.
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            pwmcd_en_t en;  // Enables handed to this channel.

            assign en.prim_en = out_en[`PWMCD_EN_PRIM_LO+c];
            assign en.comp_en = out_en[`PWMCD_EN_PRIM_LO+2+c];

            // Control, period and duty; the engine copies them at its next period start.
            always_ff @(posedge mclk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    cfg[c] <= '0;
                    ie[c]  <= 1'b0;
                end else if (mod_wr) begin
                    if (idx == CTL_IDX[c]) begin
                        ie[c]      <= wdat[`PWMCD_CTL_IE];
                        cfg[c].pol <= wdat[`PWMCD_CTL_POL];
                        cfg[c].sel <= wdat[`PWMCD_CTL_SEL_HI:`PWMCD_CTL_SEL_LO];
                    end
                    if (idx == PER_IDX[c]) begin
                        cfg[c].period <= wdat;
                    end
                    if (idx == DUTY_IDX[c]) begin
                        cfg[c].duty <= wdat;
                    end
                end
            end

            // Dead time may only change while both outputs of the channel are off,
            // since a change mid-waveform could let the two switches overlap.
            always_ff @(posedge mclk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    dt[c] <= `PWMCD_RST8;
                end else if (mod_wr && idx == DT_IDX[c] && !en.prim_en && !en.comp_en) begin
                    dt[c] <= wdat;
                end
            end

            // Overflow flag: hardware sets, software clears by writing zero; set wins.
            always_ff @(posedge mclk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    iflag[c] <= 1'b0;
                end else if (ovf[c]) begin
                    iflag[c] <= 1'b1;
                end else if (wr_go && idx == CTL_IDX[c] && !wdat[`PWMCD_CTL_IF]) begin
                    iflag[c] <= 1'b0;
                end
            end

            // Interrupt request; the global enable lives in the processor.
            always_ff @(posedge mclk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    irq_req_o[c] <= 1'b0;
                end else begin
                    irq_req_o[c] <= iflag[c] & ie[c];
                end
            end

            // The waveform engine.
            pwmcd_chan u_chan (
                .mclk_i   (mclk_i),
                .resetn_i (resetn_i),
                .tick_i   (tick),
                .cfg_i    (cfg[c]),
                .en_i     (en),
                .dead_i   (dt[c]),
                .fault_i  (flt_latch),
                .pins_o   (chan_pins_o[c]),
                .ovf_o    (ovf[c])
            );
        end
    endgenerate

    // Read multiplexer; the control register shows the live overflow flag.
    always_comb begin
        rd_mux = `PWMCD_RST8;
        unique case (idx)
            `PWMCD_IDX_LOCK:     rd_mux = lock;
            `PWMCD_IDX_OUT_EN:   rd_mux = {2'b00, out_en[3:2], 2'b00, out_en[1:0]};
            `PWMCD_IDX_FAULT:    rd_mux = {6'b00_0000, flt_latch, flt_en};
            `PWMCD_IDX_CH0_DT:   rd_mux = ch0_dt;
            `PWMCD_IDX_CH1_DT:   rd_mux = dt[0];
            `PWMCD_IDX_CH1_CTL:  rd_mux = {ie[0], iflag[0], 3'b000, cfg[0].pol, cfg[0].sel};
            `PWMCD_IDX_CH1_PER:  rd_mux = cfg[0].period;
            `PWMCD_IDX_CH1_DUTY: rd_mux = cfg[0].duty;
            `PWMCD_IDX_CH2_DT:   rd_mux = dt[1];
            `PWMCD_IDX_CH2_CTL:  rd_mux = {ie[1], iflag[1], 3'b000, cfg[1].pol, cfg[1].sel};
            `PWMCD_IDX_CH2_PER:  rd_mux = cfg[1].period;
            `PWMCD_IDX_CH2_DUTY: rd_mux = cfg[1].duty;
            default:             rd_mux = `PWMCD_RST8;
        endcase
    end

endmodule

// >>> pwmcd_drv.sv
// Switch driver model: measures high time and period of one gate line.
`timescale 1ns/10ps
module pwmcd_drv (
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        gate_i,
    output logic      [15:0] high_o,
    output logic      [15:0] per_o
);
    logic [15:0] hcnt, pcnt;  // Running high and period counts.
    logic        last;        // Gate level one clock ago.
    // A rising gate edge closes a period; counts restart at one so N clocks read as N.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {hcnt, pcnt, last, high_o, per_o} <= '0;
        end else begin
            last <= gate_i;
            if (gate_i && !last) begin
                {high_o, per_o, hcnt, pcnt} <= {hcnt, pcnt, 16'h0001, 16'h0001};
            end else begin
                hcnt <= hcnt + 16'(gate_i);
                pcnt <= pcnt + 16'h0001;
            end
        end
    end
endmodule

// >>> pwmcd_asserts.sv
// Port checker of the modulator top level.
`timescale 1ns/10ps
`include "pwmcd_map.svh"
module pwmcd_asserts #(
    parameter int NCH = 2  // Number of 8-bit channels.
) (
    input wire logic                        mclk_i,
    input wire logic                        resetn_i,
    input wire logic [9:0]                  avs_address_i,
    input wire logic                        avs_read_i,
    input wire logic                        avs_write_i,
    input wire logic [31:0]                 avs_writedata_i,
    input wire logic [3:0]                  avs_byteenable_i,
    input wire logic [31:0]                 avs_readdata_o,
    input wire logic                        avs_waitrequest_o,
    input wire logic                        fault_n_i,
    input wire pwmcd_pkg::pwmcd_pins_t [NCH-1:0] chan_pins_o,
    input wire logic [NCH-1:0]              irq_req_o
);
    logic       acc, wok;        // Access accepted; guarded write accepted.
    logic [7:0] idx, wd, lock, en, dt1;  // Index, write byte; mirrors of lock, enables, dead time.
    logic       fen, ie1, pol1;  // Mirrors of fault enable, irq enable, polarity.
    assign acc = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    assign idx = avs_address_i[9:2];
    assign wd  = avs_writedata_i[7:0];
    assign wok = acc && avs_write_i && avs_byteenable_i[0] && lock == `PWMCD_UNLOCK;
    // The mirrors follow only writes the block must honour, so a leaky guard shows up.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {lock, en, dt1, fen, ie1, pol1} <= '0;
        end else begin
            if (acc && avs_write_i && avs_byteenable_i[0] && idx == `PWMCD_IDX_LOCK) lock <= wd;
            if (wok && idx == `PWMCD_IDX_OUT_EN) en <= wd;
            if (wok && idx == `PWMCD_IDX_FAULT) fen <= wd[0];
            if (wok && idx == `PWMCD_IDX_CH1_CTL) {ie1, pol1} <= {wd[7], wd[2]};
            if (wok && idx == `PWMCD_IDX_CH1_DT && !en[0] && !en[4]) dt1 <= wd;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    chk_wait_single: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("access not answered after one wait cycle");
    chk_wait_back: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("wait request low for more than one cycle");
    chk_lock_read: assert property (
        acc && avs_read_i && idx == `PWMCD_IDX_LOCK |-> avs_readdata_o == {24'h00_0000, lock})
        else $error("lock register read back wrong");
    chk_dead_hold: assert property (
        acc && avs_read_i && idx == `PWMCD_IDX_CH1_DT |-> avs_readdata_o[7:0] == dt1)
        else $error("dead time changed while outputs enabled");
    chk_irq_gate: assert property (irq_req_o[0] |-> $past(ie1))
        else $error("interrupt request without enable");
    chk_fault_force: assert property (
        (fen && !fault_n_i) [*7] |-> chan_pins_o[0].prim == chan_pins_o[0].comp)
        else $error("fault did not force both outputs alike");
    chk_idle_level: assert property (
        (!en[0] && !en[4]) [*8] |-> chan_pins_o[0].prim == chan_pins_o[0].comp)
        else $error("disabled outputs not at rest level");
    chk_no_overlap: assert property (en[0] && en[4] && dt1 != 8'h00 |->
        !(chan_pins_o[0].prim != pol1 && chan_pins_o[0].comp != pol1))
        else $error("primary and complement active together");
endmodule
bind pwmcd_top pwmcd_asserts #(.NCH(NCH)) i_pwmcd_asserts (.mclk_i, .resetn_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .fault_n_i, .chan_pins_o, .irq_req_o);

// >>> tb_pwmcd_top.sv
// Self-checking bench of the modulator top level with random channel settings.
`timescale 1ns/10ps
`include "pwmcd_map.svh"
module tb_pwmcd_top;
    import pwmcd_pkg::*;
    logic              mclk_i = 0, resetn_i = 0, avs_read_i = 0, avs_write_i = 0;
    logic              fault_n_i = 1;
    logic [9:0]        avs_address_i = '0;
    logic [31:0]       avs_writedata_i = '0, avs_readdata_o, q;
    logic [3:0]        avs_byteenable_i = 4'hf;
    logic              avs_waitrequest_o, pl;
    pwmcd_pins_t [1:0] chan_pins_o;
    logic [1:0]        irq_req_o;
    logic [15:0]       hi [4], pe [4];  // Partner counts: even prim, odd comp.
    logic [7:0]        p, d;
    logic [7:0]        dti [2] = '{8'hD7, 8'hDC};  // Dead time index per channel.
    logic [7:0]        cti [2] = '{8'hD9, 8'hDD};  // Control index; period and duty follow.
    logic [7:0]        rg [8] = '{8'hD1, 8'hD7, 8'hDA, 8'hDB, 8'hDC, 8'hDE, 8'hDF, 8'h10};
    int                err_count = 0, checks = 0, seed = 99, dv;
    pwmcd_top #(.NCH(2)) i_pwmcd_top (.mclk_i, .resetn_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
        .avs_waitrequest_o, .fault_n_i, .chan_pins_o, .irq_req_o);
    // One switch driver model per output pin.
    for (genvar k = 0; k < 4; k++) begin : g_drv
        pwmcd_drv i_pwmcd_drv (.mclk_i, .resetn_i, .high_o(hi[k]), .per_o(pe[k]),
            .gate_i(k % 2 ? chan_pins_o[k / 2].comp : chan_pins_o[k / 2].prim));
    end
    always #50 mclk_i = ~mclk_i;
    // Bus cycle: request held until waitrequest is sampled low, then released.
    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] dat);
        int n;
        n = 0;
        @(posedge mclk_i);
        avs_address_i <= {i, 2'b00};
        avs_writedata_i <= {24'h00_0000, dat};
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge mclk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 40);
        q = avs_readdata_o;
        if (n >= 40) err_count++;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic cmp(input string s, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e, input string s);
        bus(1'b0, i, 8'h00);
        cmp(s, {8'h00, e}, q[15:0]);
    endtask
    task automatic waitp(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // Outputs go off first, so dead time and settings load before the restart.
    task automatic setch(input int c, input logic [7:0] ctl, pp, dd, dt, en);
        bus(1'b1, `PWMCD_IDX_OUT_EN, 8'h00);
        bus(1'b1, dti[c], dt);
        bus(1'b1, cti[c], ctl);
        bus(1'b1, cti[c] + 8'h01, pp);
        bus(1'b1, cti[c] + 8'h02, dd);
        bus(1'b1, `PWMCD_IDX_OUT_EN, en);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        waitp(6);
        resetn_i <= 1'b1;
        foreach (rg[k]) rd(rg[k], 8'h00, "reset value");
        bus(1'b1, 8'hDA, 8'h33);
        rd(8'hDA, 8'h00, "locked period");
        bus(1'b1, `PWMCD_IDX_LOCK, `PWMCD_UNLOCK);
        rd(`PWMCD_IDX_LOCK, `PWMCD_UNLOCK, "lock");
        $display("test reset and lock done");
        for (int c = 0; c < 2; c++) for (int s = 0; s < 4; s++) begin
            p = 8'h08 + 8'($random(seed) & 63);
            d = 8'h01 + 8'($unsigned($random(seed)) % (p - 1));
            pl = 1'($random(seed));
            dv = 2 << s;
            setch(c, {5'b0, pl, 2'(s)}, p, d, 8'h00, 8'h01 << c);
            waitp(3 * p * dv + 8);
            cmp("period", 16'(p * dv), pe[2 * c]);
            cmp("high time", 16'(pl ? (p - d) * dv : d * dv), hi[2 * c]);
        end
        $display("test random waveforms done");
        for (int k = 0; k < 4; k++) begin
            pl = k[0];
            setch(0, {5'b0, pl, 2'b00}, k[1] ? 8'h00 : 8'h14, 8'h1e, 8'h00, 8'h01);
            repeat (3) begin
                waitp(41);
                cmp("steady", 16'(k[1] ? pl : !pl), chan_pins_o[0].prim);
            end
        end
        $display("test steady levels done");
        setch(1, 8'h00, 8'h20, 8'h08, 8'h00, 8'h20);
        waitp(300);
        cmp("comp high", 16'h0030, hi[3]);
        cmp("comp period", 16'h0040, pe[3]);
        cmp("prim off", 16'h0000, chan_pins_o[1].prim);
        setch(0, 8'h00, 8'h20, 8'h10, 8'h04, 8'h11);
        waitp(300);
        cmp("dead period", 16'h0040, pe[1]);
        cmp("dead gap", 16'h001c, hi[1]);
        bus(1'b1, 8'hD7, 8'h40);
        rd(8'hD7, 8'h04, "dead while on");
        setch(0, 8'h00, 8'h0a, 8'h06, 8'h02, 8'h11);
        waitp(100);
        cmp("comp held", 16'h0000, chan_pins_o[0].comp);
        $display("test complement and dead time done");
        setch(0, 8'h04, 8'h20, 8'h10, 8'h00, 8'h11);
        bus(1'b1, `PWMCD_IDX_FAULT, 8'h01);
        fault_n_i <= 1'b0;
        waitp(10);
        fault_n_i <= 1'b1;
        waitp(50);
        cmp("fault pins", 16'h0003, {14'h0, chan_pins_o[0]});
        bus(1'b1, `PWMCD_IDX_FAULT, 8'h02);
        waitp(300);
        cmp("after clear", 16'h0040, pe[0]);
        $display("test fault done");
        for (int c = 0; c < 2; c++) begin
            setch(c, 8'h80, 8'h20, 8'h10, 8'h00, 8'h01 << c);
            waitp(100);
            cmp("irq on", 16'h0001, 16'(irq_req_o[c]));
            bus(1'b1, cti[c], 8'h00);
            waitp(3);
            cmp("irq off", 16'h0000, 16'(irq_req_o[c]));
        end
        $display("test interrupt request done");
        stop_test;
    end
    initial begin
        #(80000 * 100);
        err_count++;
        stop_test;
    end
endmodule
